// file: logic/board_io_direction_config.sv
// board_io_direction_config: three direction registers of the board control
// lines behind an Avalon-MM slave, the target reset controls, and the pin
// drivers that turn each direction bit into an output enable.
// assumes line levels come from output-port logic on the same clock, and that
// pin inputs arrive from outside the clock domain.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "board_io_regs.svh"

module board_io_direction_config (
    input  wire logic                       clock,
    input  wire logic                       nrst,
    // avalon-mm slave, byte address
    input  wire logic [7:0]                 address,
    input  wire logic                       read,
    input  wire logic                       write,
    input  wire logic [3:0]                 byteenable,
    input  wire logic [31:0]                writedata,
    output      logic [31:0]                readdata,
    output      logic                       waitrequest,
    // board control lines
    input  wire logic [`LINE_COUNT-1:0]     line_level,
    input  wire logic [`LINE_COUNT-1:0]     line_in,
    output      logic [`LINE_COUNT-1:0]     line_out,
    output      logic [`LINE_COUNT-1:0]     line_oe,
    // target reset controls
    output      logic                       first_target_reset,
    output      logic                       second_target_reset,
    // direction fields, 1 = input
    output      logic                       osc_a_enable_direction,
    output      logic                       osc_b_enable_direction,
    output      logic                       spdif_clock_source_direction,
    output      logic                       spdif_clock_package_direction,
    output      logic                       spdif_buffer_reset_direction,
    output      logic                       aux_port_format_direction,
    output      logic                       primary_port_format_direction,
    output      logic                       aux_port_role_direction,
    output      logic                       primary_port_role_direction,
    output      logic                       mclk_header_b_role_direction,
    output      logic                       mclk_header_a_role_direction,
    output      logic                       board_mclk_b_enable_direction,
    output      logic                       board_mclk_a_enable_direction,
    output      logic                       leadframe_mclk_oe_direction,
    output      logic                       chipscale_mclk_oe_direction
);
    import board_io_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // the pin map below names fifteen fields; another count would leave lines
    // without a direction bit, or direction bits without a line
    if (`LINE_COUNT != 15) begin : g_bad_line_count
        $error("board_io_direction_config: line count must be 15");
    end

    // reserved bits must stay outside the write masks, or software could move them
    if ((`DIR_CLOCK_RESET_WMASK & 8'h08) != 8'h00) begin : g_bad_clock_mask
        $error("board_io_direction_config: reserved bit 3 is writable");
    end

    if ((`DIR_MCLK_OE_WMASK & 8'hFC) != 8'h00) begin : g_bad_mclk_mask
        $error("board_io_direction_config: reserved bits 7 to 2 are writable");
    end

    // reserved bits of the third register read back as ones
    if ((`DIR_MCLK_OE_RESET & 8'hFC) != 8'hFC) begin : g_bad_mclk_reset
        $error("board_io_direction_config: reserved bits must reset to ones");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus handshake

    bus_state_t              state;
    bus_state_t              next_state;
    logic                    request;
    logic                    accept;
    logic                    low_lane_write;
    logic [31:0]             next_readdata;
    logic                    load_readdata;

    assign request = read | write;

    // every request waits exactly one cycle; the answer edge is the one with
    // waitrequest low, so register reads and writes line up on the same edge
    assign waitrequest    = request & (state == bus_idle);
    assign accept         = request & (state == bus_answer);
    assign low_lane_write = write & accept & byteenable[0];

    // readdata is loaded while the master still waits, so it already stands at
    // the answer edge; writes leave it alone
    assign load_readdata  = read & waitrequest;

    always_comb begin
        case (state)
            bus_idle: begin
                next_state = request ? bus_answer : bus_idle;
            end
            bus_answer: begin
                next_state = bus_idle;
            end
            default: begin
                next_state = bus_idle;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= bus_idle;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // address decode

    logic                    hit_clock_reset;
    logic                    hit_audio_mode;
    logic                    hit_mclk_oe;
    logic                    hit_line_level;
    logic                    write_clock_reset;
    logic                    write_audio_mode;
    logic                    write_mclk_oe;

    assign hit_clock_reset   = address == `DIR_CLOCK_RESET_ADDR;
    assign hit_audio_mode    = address == `DIR_AUDIO_MODE_ADDR;
    assign hit_mclk_oe       = address == `DIR_MCLK_OE_ADDR;
    assign hit_line_level    = address == `LINE_LEVEL_ADDR;

    assign write_clock_reset = low_lane_write & hit_clock_reset;
    assign write_audio_mode  = low_lane_write & hit_audio_mode;
    assign write_mclk_oe     = low_lane_write & hit_mclk_oe;

    ////////////////////////////////////////////////////////////////////////////////
    // direction registers

    byte_t                   dir_clock_reset;
    byte_t                   dir_audio_mode;
    byte_t                   dir_mclk_oe;

    // reserved bit 3 is not writable and keeps its reset value
    dir_register #(
        .RESET_VALUE (`DIR_CLOCK_RESET_RESET),
        .WRITE_MASK  (`DIR_CLOCK_RESET_WMASK)
    ) line_direction_clock_reset (
        .clock        (clock),
        .nrst         (nrst),
        .write_strobe (write_clock_reset),
        .write_data   (writedata[7:0]),
        .value        (dir_clock_reset)
    );

    dir_register #(
        .RESET_VALUE (`DIR_AUDIO_MODE_RESET),
        .WRITE_MASK  (`DIR_AUDIO_MODE_WMASK)
    ) line_direction_audio_mode (
        .clock        (clock),
        .nrst         (nrst),
        .write_strobe (write_audio_mode),
        .write_data   (writedata[7:0]),
        .value        (dir_audio_mode)
    );

    // bits 7 to 2 are reserved and read back as ones
    dir_register #(
        .RESET_VALUE (`DIR_MCLK_OE_RESET),
        .WRITE_MASK  (`DIR_MCLK_OE_WMASK)
    ) line_direction_mclk_oe (
        .clock        (clock),
        .nrst         (nrst),
        .write_strobe (write_mclk_oe),
        .write_data   (writedata[7:0]),
        .value        (dir_mclk_oe)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // direction fields

    assign osc_a_enable_direction        = dir_clock_reset[`OSC_A_ENABLE_BIT];
    assign osc_b_enable_direction        = dir_clock_reset[`OSC_B_ENABLE_BIT];
    assign spdif_clock_source_direction  = dir_clock_reset[`SPDIF_SOURCE_BIT];
    assign spdif_clock_package_direction = dir_clock_reset[`SPDIF_PACKAGE_BIT];
    assign spdif_buffer_reset_direction  = dir_clock_reset[`SPDIF_BUFFER_RESET_BIT];
    assign aux_port_format_direction     = dir_audio_mode[7];
    assign primary_port_format_direction = dir_audio_mode[6];
    assign aux_port_role_direction       = dir_audio_mode[5];
    assign primary_port_role_direction   = dir_audio_mode[4];
    assign mclk_header_b_role_direction  = dir_audio_mode[3];
    assign mclk_header_a_role_direction  = dir_audio_mode[2];
    assign board_mclk_b_enable_direction = dir_audio_mode[1];
    assign board_mclk_a_enable_direction = dir_audio_mode[0];
    assign leadframe_mclk_oe_direction   = dir_mclk_oe[`LEADFRAME_MCLK_OE_BIT];
    assign chipscale_mclk_oe_direction   = dir_mclk_oe[`CHIPSCALE_MCLK_OE_BIT];

    // reset controls come straight from the register: 1 holds the target in reset
    assign second_target_reset = dir_clock_reset[`SECOND_TARGET_RESET_BIT];
    assign first_target_reset  = dir_clock_reset[`FIRST_TARGET_RESET_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // pin drivers

    logic [`LINE_COUNT-1:0]  line_is_input;
    logic [`LINE_COUNT-1:0]  line_sync;

    // line order: first register fields, then second register bits 7..0,
    // then third register bits 1..0
    assign line_is_input = {
        chipscale_mclk_oe_direction,
        leadframe_mclk_oe_direction,
        board_mclk_a_enable_direction,
        board_mclk_b_enable_direction,
        mclk_header_a_role_direction,
        mclk_header_b_role_direction,
        primary_port_role_direction,
        aux_port_role_direction,
        primary_port_format_direction,
        aux_port_format_direction,
        spdif_buffer_reset_direction,
        spdif_clock_package_direction,
        spdif_clock_source_direction,
        osc_b_enable_direction,
        osc_a_enable_direction
    };

    // a line set to input is released, so the far side may drive it
    generate
        for (genvar i = 0; i < `LINE_COUNT; i++) begin : g_line
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    line_out[i] <= 1'b0;
                end else begin
                    line_out[i] <= line_level[i];
                end
            end

            // enables stay low during reset, so no line is driven before the
            // direction registers hold their reset values
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    line_oe[i] <= 1'b0;
                end else begin
                    line_oe[i] <= ~line_is_input[i];
                end
            end
        end
    endgenerate

    // pins come from the board, so they cross two flip-flops before readback
    level_sync #(
        .WIDTH (`LINE_COUNT)
    ) pin_sync (
        .clock    (clock),
        .nrst     (nrst),
        .async_in (line_in),
        .sync_out (line_sync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // read data

    logic [31:0]             word_clock_reset;
    logic [31:0]             word_audio_mode;
    logic [31:0]             word_mclk_oe;
    logic [31:0]             word_line_level;

    // one register per 32-bit word, data in the low byte (line levels in bits 14..0), upper bits read zero
    assign word_clock_reset = {24'h000000, dir_clock_reset};
    assign word_audio_mode  = {24'h000000, dir_audio_mode};
    assign word_mclk_oe     = {24'h000000, dir_mclk_oe};
    assign word_line_level  = {17'h00000, line_sync};

    // unmapped addresses read as zero and ignore writes
    assign next_readdata =
        hit_clock_reset ? word_clock_reset :
        hit_audio_mode  ? word_audio_mode  :
        hit_mclk_oe     ? word_mclk_oe     :
        hit_line_level  ? word_line_level  :
                          32'h00000000;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            readdata <= 32'h00000000;
        end else if (load_readdata) begin
            readdata <= next_readdata;
        end
    end

endmodule

// file: logic/dir_register.sv
// dir_register: one 8-bit read/write register with a reset value and a
// write mask; bits outside the mask hold their reset value.
// assumes the write strobe is a single-cycle, same-clock pulse.
`timescale 1ns/10ps

module dir_register #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK  = 8'hFF
) (
    input  wire logic                clock,
    input  wire logic                nrst,
    input  wire logic                write_strobe,
    input  wire board_io_pkg::byte_t write_data,
    output      board_io_pkg::byte_t value
);
    import board_io_pkg::*;

    byte_t next_value;

    assign next_value = (write_data & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            value <= RESET_VALUE;
        end else if (write_strobe) begin
            value <= next_value;
        end
    end

endmodule

// file: logic/level_sync.sv
// level_sync: two-flip-flop synchroniser for a group of slow level signals.
// assumes each bit changes rarely; bits are not sampled coherently.
`timescale 1ns/10ps

module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] async_in,
    output      logic [WIDTH-1:0] sync_out
);
    import board_io_pkg::*;

    logic [WIDTH-1:0] first_stage;

    if (WIDTH < 1) begin : g_bad_width
        $error("level_sync: WIDTH must be at least 1");
    end

    // first_stage feeds only the second flip-flop
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            first_stage <= '0;
            sync_out    <= '0;
        end else begin
            first_stage <= async_in;
            sync_out    <= first_stage;
        end
    end

endmodule

// file: pkg/board_io_pkg.sv
// board_io_pkg: types shared by the direction-register block and its bench.
// assumes nothing of its surroundings.
package board_io_pkg;

    typedef enum logic [0:0] {
        bus_idle,
        bus_answer
    } bus_state_t;

    typedef logic [7:0] byte_t;

endpackage

// file: pkg/board_io_regs.svh
// board_io_regs.svh: offsets, field positions, reset values and masks of the
// direction registers; included by the direction-register block, not by its bench.
//
// Operation
// - The first direction register at index 0x0C resets to 0x0B, and its bit 7 makes the 24.576 MHz oscillator enable line an output (0, default) or an input (1).
// - Bit 6 of the first direction register makes the 22.5792 MHz oscillator enable line an output (0, default) or an input (1).
// - Bit 5 of the first direction register makes the S/PDIF clock-master source select line an output (0, default) or an input (1).
// - Bit 4 of the first direction register makes the S/PDIF clock package select line an output (0, default) or an input (1).
// - Bit 2 of the first direction register makes the S/PDIF buffer reset line an output (0, default) or an input (1), and bit 3 is reserved.
// - The second direction register at index 0x0D resets to 0x00, and its bit 7 makes the auxiliary port format line an output (0) or an input (1).
// - Bit 6 of the second direction register makes the primary port format line an output (0, default) or an input (1).
// - Bit 5 of the second direction register makes the auxiliary port role line an output (0, default) or an input (1).
// - Bit 4 of the second direction register makes the primary port role line an output (0, default) or an input (1).
// - Bit 3 of the second direction register makes the second master-clock header role line an output (0, default) or an input (1).
// - Bit 2 of the second direction register makes the first master-clock header role line an output (0, default) or an input (1).
// - Bit 1 of the second direction register makes the second board master-clock enable line an output (0, default) or an input (1).
// - Bit 0 of the second direction register makes the first board master-clock enable line an output (0, default) or an input (1).
// - The third direction register at index 0x0E resets to 0xFC with bits 7 to 2 reserved, and its bit 1 makes the leadframe master-clock output enable line an output (0) or an input (1).
// - Bit 0 of the third direction register makes the chip-scale master-clock output enable line an output (0, default) or an input (1).

`ifndef BOARD_IO_REGS_SVH
`define BOARD_IO_REGS_SVH

// register indices; the byte address on the bus is four times the index
`define DIR_CLOCK_RESET_INDEX   8'h0C
`define DIR_AUDIO_MODE_INDEX    8'h0D
`define DIR_MCLK_OE_INDEX       8'h0E
`define LINE_LEVEL_INDEX        8'h10

`define DIR_CLOCK_RESET_ADDR    8'h30
`define DIR_AUDIO_MODE_ADDR     8'h34
`define DIR_MCLK_OE_ADDR        8'h38
`define LINE_LEVEL_ADDR         8'h40

`define DIR_CLOCK_RESET_RESET   8'h0B
`define DIR_AUDIO_MODE_RESET    8'h00
`define DIR_MCLK_OE_RESET       8'hFC

// writable bits; reserved bits keep their reset value
`define DIR_CLOCK_RESET_WMASK   8'hF7
`define DIR_AUDIO_MODE_WMASK    8'hFF
`define DIR_MCLK_OE_WMASK       8'h03

// first direction register fields
`define OSC_A_ENABLE_BIT        7
`define OSC_B_ENABLE_BIT        6
`define SPDIF_SOURCE_BIT        5
`define SPDIF_PACKAGE_BIT       4
`define SPDIF_BUFFER_RESET_BIT  2
`define SECOND_TARGET_RESET_BIT 1
`define FIRST_TARGET_RESET_BIT  0

// third direction register fields
`define LEADFRAME_MCLK_OE_BIT   1
`define CHIPSCALE_MCLK_OE_BIT   0

`define LINE_COUNT              15

`endif

// file: tb/board_io_direction_config_props.sv
// board_io_direction_config_props: bus and pin-driver assertions of the block.
// assumes one clock domain, and that no write follows another within 2 cycles.
`timescale 1ns/10ps

module board_io_direction_config_props (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic [14:0] line_oe,
    input wire logic        first_target_reset,
    input wire logic        second_target_reset
);
    logic [7:0] wd;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    // last accepted write data, so the late pin-driver checks see it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) wd <= 8'h00;
        else if (write && !waitrequest) wd <= writedata[7:0];
    end

    sequence wr_acc(logic [7:0] a);
        write && !waitrequest && address == a && byteenable[0];
    endsequence
    sequence rd_acc(logic [7:0] a);
        read && !waitrequest && address == a;
    endsequence

    one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered after one wait cycle");
    reset_state_a: assert property ($rose(nrst) |->
        {second_target_reset, first_target_reset} == 2'b11 ##1 line_oe == 15'h7FFF)
        else $error("wrong state after reset");
    target_write_a: assert property (wr_acc(8'h30) |=>
        {second_target_reset, first_target_reset} == wd[1:0])
        else $error("target reset does not follow write");
    clock_dir_a: assert property (wr_acc(8'h30) |->
        ##2 line_oe[4:0] == ~{wd[2], wd[4], wd[5], wd[6], wd[7]})
        else $error("clock line enables do not follow write");
    audio_dir_a: assert property (wr_acc(8'h34) |-> ##2 line_oe[12:5] ==
        ~{wd[0], wd[1], wd[2], wd[3], wd[4], wd[5], wd[6], wd[7]})
        else $error("audio line enables do not follow write");
    mclk_dir_a: assert property (wr_acc(8'h38) |-> ##2 line_oe[14:13] == ~{wd[0], wd[1]})
        else $error("clock enable lines do not follow write");
    read_clock_a: assert property (rd_acc(8'h30) |-> readdata == {24'h0, ~line_oe[0],
        ~line_oe[1], ~line_oe[2], ~line_oe[3], 1'b1, ~line_oe[4], second_target_reset,
        first_target_reset})
        else $error("first register readback wrong");
    read_mclk_a: assert property (rd_acc(8'h38) |->
        readdata == {24'h0, 6'h3F, ~line_oe[13], ~line_oe[14]})
        else $error("third register readback wrong");
endmodule

bind board_io_direction_config board_io_direction_config_props u_props (
    .clock(clock), .nrst(nrst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .line_oe(line_oe), .first_target_reset(first_target_reset),
    .second_target_reset(second_target_reset));

// file: tb/board_io_direction_config_tb.sv
// board_io_direction_config_tb: register, pin-driver and reset tests of the block.
// assumes the board model resolves the lines and the checker is bound in.
`timescale 1ns/10ps

module board_io_direction_config_tb;
    import board_io_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q;} row_t;
    logic        clock, nrst, read, write, waitrequest, t1, t2;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata, readdata, q;
    logic [14:0] line_level, line_in, line_out, line_oe;
    wire logic [14:0] dirs;
    byte_t       mirror [3];
    int          n_errors, total_checks;
    row_t        rows [8] = '{'{8'h30, 8'hFF, 8'hFF}, '{8'h30, 8'h00, 8'h08},
        '{8'h30, 8'hA3, 8'hAB}, '{8'h34, 8'hA5, 8'hA5}, '{8'h34, 8'h5A, 8'h5A},
        '{8'h38, 8'hFF, 8'hFF}, '{8'h38, 8'h01, 8'hFD}, '{8'h3C, 8'hFF, 8'h00}};

    board_io_direction_config u_board_io_direction_config (.clock(clock), .nrst(nrst),
        .address(address), .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .line_level(line_level), .line_in(line_in), .line_out(line_out),
        .line_oe(line_oe), .first_target_reset(t1), .second_target_reset(t2),
        .osc_a_enable_direction(dirs[0]), .osc_b_enable_direction(dirs[1]),
        .spdif_clock_source_direction(dirs[2]), .spdif_clock_package_direction(dirs[3]),
        .spdif_buffer_reset_direction(dirs[4]), .aux_port_format_direction(dirs[5]),
        .primary_port_format_direction(dirs[6]), .aux_port_role_direction(dirs[7]),
        .primary_port_role_direction(dirs[8]), .mclk_header_b_role_direction(dirs[9]),
        .mclk_header_a_role_direction(dirs[10]), .board_mclk_b_enable_direction(dirs[11]),
        .board_mclk_a_enable_direction(dirs[12]), .leadframe_mclk_oe_direction(dirs[13]),
        .chipscale_mclk_oe_direction(dirs[14]));
    board_lines u_board_lines (.line_out(line_out), .line_oe(line_oe), .line_in(line_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // waitrequest and readdata are taken at the rising edge, before that edge's
    // updates land; only the watchdog ends a wait that never ends
    task automatic bus(input logic rw, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        read <= !rw;
        write <= rw;
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0);
        q = readdata;
        check("wait cycles", n, 32'd2);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
        logic [7:0] m;
        bus(1'b1, a, d, be);
        m = (a == 8'h30) ? 8'hF7 : (a == 8'h34) ? 8'hFF : 8'h03;
        if (be[0] && a >= 8'h30 && a <= 8'h38)
            mirror[(a - 8'h30) >> 2] = (mirror[(a - 8'h30) >> 2] & ~m) | (d & m);
    endtask

    task automatic check_all();
        logic [7:0]  r;
        logic [14:0] e;
        r = {<<{mirror[1]}};
        e = {mirror[2][0], mirror[2][1], r, mirror[0][2], mirror[0][4], mirror[0][5],
             mirror[0][6], mirror[0][7]};
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, 8'h30 + 8'(4 * i), 8'h00, 4'hF);
            check("register", q, {24'h0, mirror[i]});
        end
        check("direction", {17'h0, dirs}, {17'h0, e});
        check("output enable", {17'h0, line_oe}, {17'h0, ~e});
        check("target reset", {30'h0, t2, t1}, {30'h0, mirror[0][1:0]});
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        stop_test();
    end

    initial begin
        {nrst, read, write, address, byteenable, writedata, line_level} = '0;
        mirror = '{8'h0B, 8'h00, 8'hFC};
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        check_all();
        $display("test reset values done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, 4'hF);
            bus(1'b0, rows[i].a, 8'h00, 4'hF);
            check("readback", q, {24'h0, rows[i].q});
            check_all();
        end
        $display("test register rows done");
        wr(8'h34, 8'hFF, 4'hE);
        check_all();
        $display("test byte lane done");
        // all lines inputs: pins then show only what the board drives
        wr(8'h30, 8'hF4, 4'hF);
        wr(8'h34, 8'hFF, 4'hF);
        wr(8'h38, 8'h03, 4'hF);
        check_all();
        repeat (4) @(posedge clock);
        bus(1'b0, 8'h40, 8'h00, 4'hF);
        check("far level", q, 32'h2A5C);
        $display("test input lines done");
        line_level <= 15'h1234;
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        mirror = '{8'h0B, 8'h00, 8'hFC};
        repeat (4) @(posedge clock);
        check_all();
        bus(1'b0, 8'h40, 8'h00, 4'hF);
        check("driven level", q, 32'h1234);
        $display("test mid-run reset done");
        stop_test();
    end
endmodule

// file: tb/board_lines.sv
// board_lines: the board side of the control lines; a line not driven by the
// block shows the far side's own level, so a stale value passes only where FAR_LEVEL matches the driven level.
`timescale 1ns/10ps

module board_lines #(
    parameter logic [14:0] FAR_LEVEL = 15'h2A5C
) (
    input  wire logic [14:0] line_out,
    input  wire logic [14:0] line_oe,
    output      logic [14:0] line_in
);
    assign line_in = (line_oe & line_out) | (~line_oe & FAR_LEVEL);
endmodule
